// ==== rtl/cycle_timer.sv ====
// Wrapping cycle timer with a parameterised limit
`timescale 1ns/100ps
module cycle_timer #(
	parameter int unsigned WIDTH = 20,
	parameter logic [WIDTH-1:0] LIMIT = 20'h00010
) (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic clear,
	input wire logic run,
	output logic done
);
	// Elapsed cycles
	logic [WIDTH-1:0] count;
	logic [WIDTH-1:0] next_count;

	// Done while running at the last cycle of the limit
	assign done = run && !clear && (count == LIMIT - 1'b1);

	// Count while running, wrap at the limit so done is a one-cycle pulse per period
	always_comb begin
		next_count = count;
		if (clear) begin
			next_count = '0;
		end else if (run && count == LIMIT - 1'b1) begin
			next_count = '0;
		end else if (run) begin
			next_count = count + 1'b1;
		end
	end

	// Register the count
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			count <= '0;
		end else begin
			count <= next_count;
		end
	end
endmodule : cycle_timer

// ==== rtl/fault_sequencer.sv ====
// Protection sequencer for a half-bridge resonant converter
`timescale 1ns/100ps
module fault_sequencer
	import protection_pkg::*;
#(
	parameter logic [7:0] EXT_BLANK_COUNT = EXT_BLANK_COUNT_DEF,
	parameter logic [7:0] RESTART_COUNT = RESTART_COUNT_DEF,
	parameter int unsigned RAMP_CYCLES = OCP_RAMP_CYCLES,
	parameter int unsigned BLANK_CYCLES = OLP_BLANK_CYCLES,
	parameter int unsigned STEP_CYCLES = SS_STEP_CYCLES,
	parameter int unsigned RECOV_CYCLES = RECOVERY_CYCLES,
	parameter int unsigned SETTLE_CYC = SETTLE_CYCLES
) (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic cs_above_upper,
	input wire logic cs_below_lower,
	input wire logic cs_latch_level,
	input wire logic feedback_above_upper,
	input wire logic feedback_below_lower,
	input wire logic feedback_at_zero,
	input wire logic input_sense_above_on,
	input wire logic input_sense_high_level,
	input wire logic input_sense_low_level,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output logic [BOOST_W-1:0] boost_level,
	output logic [4:0] soft_start_offset,
	output logic soft_start_active,
	output logic switching_enable,
	output logic feedback_contrib_enable,
	output logic soft_start_contrib_enable,
	output logic feedback_discharge_switch,
	output logic input_sense_discharge_switch,
	output logic restart_charge_source,
	output logic hysteresis_source_enable,
	output logic latched_off
);
	// Ramp end point of the boost counter
	localparam logic [BOOST_W-1:0] RAMP_MAX = BOOST_W'(RAMP_CYCLES);

	state_t state; // Sequencer state
	state_t next_state;
	logic [7:0] eb_count; // Extended blanking cycles done
	logic [7:0] next_eb_count;
	logic [7:0] rs_count; // Restart delay cycles done
	logic [7:0] next_rs_count;
	logic [4:0] next_ss_offset;
	logic [BOOST_W-1:0] next_boost;
	logic [1:0] ctrl; // Software control bits
	logic [1:0] next_ctrl;
	logic ack; // Bus answer cycle
	logic next_ack;
	logic [31:0] next_rdata;
	logic uv_en; // Undervoltage stop enabled
	logic boost_en; // Frequency boost enabled
	logic mains_low; // Mains below range while stop is enabled
	logic in_switch; // States with gates running
	logic blank_run; // Fixed blanking timer running
	logic blank_done;
	logic step_done;
	logic recov_done;
	logic settle_done;
	logic req;

	assign uv_en = ctrl[CTRL_UV_EN_BIT];
	assign boost_en = ctrl[CTRL_BOOST_EN_BIT];
	assign mains_low = uv_en && !input_sense_above_on;
	assign in_switch = state inside {ST_SOFT_START, ST_NORMAL, ST_EB_DISCHARGE, ST_EB_CHARGE,
		ST_FINAL_PULL, ST_RECOVERY};
	// Only normal operation measures the feedback excursion
	assign blank_run = (state == ST_NORMAL) && feedback_above_upper;

	// Output decode from the state register
	assign switching_enable = in_switch;
	assign soft_start_active = (state == ST_SOFT_START);
	assign feedback_contrib_enable = state inside {ST_SOFT_START, ST_NORMAL};
	assign soft_start_contrib_enable = (state == ST_SOFT_START);
	assign feedback_discharge_switch = state inside {ST_EB_DISCHARGE, ST_FINAL_PULL};
	assign input_sense_discharge_switch = state inside {ST_OLP_ENTRY, ST_OLP_DISCHARGE};
	assign restart_charge_source = (state == ST_OLP_CHARGE);
	assign hysteresis_source_enable = !(state inside {ST_OLP_ENTRY, ST_OLP_CHARGE,
		ST_OLP_DISCHARGE});
	assign latched_off = (state == ST_LATCHED);

	// Fixed overload blanking, restarted by any short excursion
	cycle_timer #(.WIDTH(TIMER_W), .LIMIT(TIMER_W'(BLANK_CYCLES))) u_blank (
		.sys_clk(sys_clk), .rst_b(rst_b), .clear(!blank_run), .run(blank_run), .done(blank_done));
	// Soft start step pacing
	cycle_timer #(.WIDTH(TIMER_W), .LIMIT(TIMER_W'(STEP_CYCLES))) u_step (
		.sys_clk(sys_clk), .rst_b(rst_b), .clear(state != ST_SOFT_START), .run(1'b1), .done(step_done));
	// Recovery window after the final pull-down
	cycle_timer #(.WIDTH(TIMER_W), .LIMIT(TIMER_W'(RECOV_CYCLES))) u_recov (
		.sys_clk(sys_clk), .rst_b(rst_b), .clear(state != ST_RECOVERY), .run(1'b1), .done(recov_done));
	// Input-sense settle blanking
	cycle_timer #(.WIDTH(TIMER_W), .LIMIT(TIMER_W'(SETTLE_CYC))) u_settle (
		.sys_clk(sys_clk), .rst_b(rst_b), .clear(state != ST_SETTLE), .run(1'b1), .done(settle_done));

	// Sequencer next state and fault counters
	always_comb begin
		next_state = state;
		next_eb_count = eb_count;
		next_rs_count = rs_count;
		next_ss_offset = soft_start_offset;
		unique case (state)
			ST_UV_STOP: begin
				// Wait for mains back in range
				if (!mains_low) begin
					next_state = ST_SOFT_START;
					next_ss_offset = SS_START;
				end
			end
			ST_SOFT_START: begin
				// One offset step per step period, 32 steps in all
				if (step_done) begin
					if (soft_start_offset == 5'h00) begin
						next_state = ST_NORMAL;
					end else begin
						next_ss_offset = soft_start_offset - 5'h01;
					end
				end
			end
			ST_NORMAL: begin
				// Feedback held high past the fixed blanking
				if (blank_done) begin
					next_state = ST_EB_DISCHARGE;
					next_eb_count = 8'h00;
				end
			end
			ST_EB_DISCHARGE: begin
				// Discharge switch on until the lower level
				if (feedback_below_lower) begin
					next_state = ST_EB_CHARGE;
				end
			end
			ST_EB_CHARGE: begin
				// Recharge reached the upper level
				if (feedback_above_upper) begin
					next_eb_count = 8'(eb_count + 8'h01);
					if (8'(eb_count + 8'h01) == EXT_BLANK_COUNT) begin
						next_state = ST_FINAL_PULL;
					end else begin
						next_state = ST_EB_DISCHARGE;
					end
				end
			end
			ST_FINAL_PULL: begin
				// Pull the pin to zero
				if (feedback_at_zero) begin
					next_state = ST_RECOVERY;
				end
			end
			ST_RECOVERY: begin
				if (feedback_above_upper) begin
					next_state = ST_OLP_ENTRY;
					next_rs_count = 8'h00;
				end else if (recov_done) begin
					next_state = ST_NORMAL;
					next_eb_count = 8'h00;
					next_rs_count = 8'h00;
				end
			end
			ST_OLP_ENTRY: begin
				// Discharge the sense capacitor to its low level
				if (input_sense_low_level) begin
					next_state = ST_OLP_CHARGE;
				end
			end
			ST_OLP_CHARGE: begin
				// Charge source on until the high level
				if (input_sense_high_level) begin
					next_state = ST_OLP_DISCHARGE;
				end
			end
			ST_OLP_DISCHARGE: begin
				// Discharge back down and count the cycle
				if (input_sense_low_level) begin
					next_rs_count = 8'(rs_count + 8'h01);
					if (8'(rs_count + 8'h01) == RESTART_COUNT) begin
						next_state = ST_SETTLE;
					end else begin
						next_state = ST_OLP_CHARGE;
					end
				end
			end
			ST_SETTLE: begin
				// Restart only with the input sense above turn-on
				if (settle_done) begin
					next_eb_count = 8'h00;
					next_rs_count = 8'h00;
					if (input_sense_above_on) begin
						next_state = ST_SOFT_START;
						next_ss_offset = SS_START;
					end else begin
						next_state = ST_UV_STOP;
					end
				end
			end
			ST_LATCHED: begin
				// Held until supply power-on reset
				next_state = ST_LATCHED;
			end
		endcase
		// Mains undervoltage stops any switching state
		if (in_switch && mains_low) begin
			next_state = ST_UV_STOP;
			next_eb_count = 8'h00;
		end
		// Winding short latches off with top priority
		if (cs_latch_level) begin
			next_state = ST_LATCHED;
		end
	end

	// Sequencer registers, loaded by power-on reset to ST_UV_STOP with both counters cleared
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			state <= ST_UV_STOP;
			eb_count <= 8'h00;
			rs_count <= 8'h00;
			soft_start_offset <= SS_START;
		end else begin
			state <= next_state;
			eb_count <= next_eb_count;
			rs_count <= next_rs_count;
			soft_start_offset <= next_ss_offset;
		end
	end

	// Boost ramp: one count per cycle, full scale in the ramp time
	always_comb begin
		next_boost = boost_level;
		if (cs_above_upper) begin
			if (boost_en && boost_level != RAMP_MAX) begin
				next_boost = boost_level + 1'b1;
			end
		end else if (cs_below_lower) begin
			if (boost_level != '0) begin
				next_boost = boost_level - 1'b1;
			end
		end
		// Otherwise hold between the thresholds
	end

	// Register the boost level
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			boost_level <= '0;
		end else begin
			boost_level <= next_boost;
		end
	end

	// Avalon slave: one wait cycle, then answer
	assign req = avs_read || avs_write;
	assign avs_waitrequest = req && !ack;

	always_comb begin
		next_ack = req && !ack;
		next_ctrl = ctrl;
		next_rdata = avs_readdata;
		// Write commits on the answer cycle
		if (avs_write && ack && avs_address == REG_CONTROL && avs_byteenable[0]) begin
			next_ctrl = avs_writedata[1:0];
		end
		// Read data prepared for the answer cycle
		if (avs_read && !ack) begin
			next_rdata = 32'h00000000;
			unique case (avs_address)
				REG_CONTROL: next_rdata[1:0] = ctrl;
				REG_STATUS: begin
					next_rdata[STAT_STATE_LSB +: 12] = state;
					next_rdata[STAT_SWITCH_BIT] = switching_enable;
					next_rdata[STAT_LATCH_BIT] = latched_off;
				end
				REG_LEVELS: begin
					next_rdata[LEV_BOOST_LSB +: BOOST_W] = boost_level;
					next_rdata[LEV_SS_LSB +: 5] = soft_start_offset;
				end
				REG_COUNTS: begin
					next_rdata[CNT_EB_LSB +: 8] = eb_count;
					next_rdata[CNT_RS_LSB +: 8] = rs_count;
				end
				default: next_rdata = 32'h00000000;
			endcase
		end
	end

	// Register bus state
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			ack <= 1'b0;
			ctrl <= CTRL_RESET;
			avs_readdata <= 32'h00000000;
		end else begin
			ack <= next_ack;
			ctrl <= next_ctrl;
			avs_readdata <= next_rdata;
		end
	end

	property p_latch;
		@(posedge sys_clk) disable iff (!rst_b) cs_latch_level |=> latched_off && !switching_enable;
	endproperty
	a_latch: assert property (p_latch) else $error("latch not taken");

	property p_latch_hold;
		@(posedge sys_clk) disable iff (!rst_b) latched_off |=> latched_off [*3];
	endproperty
	a_latch_hold: assert property (p_latch_hold) else $error("latch released");

	property p_boost_up;
		@(posedge sys_clk) disable iff (!rst_b)
		cs_above_upper && boost_en && boost_level != RAMP_MAX |=> boost_level == $past(boost_level) + 1'b1;
	endproperty
	a_boost_up: assert property (p_boost_up) else $error("boost did not rise");

	property p_boost_down;
		@(posedge sys_clk) disable iff (!rst_b)
		!cs_above_upper && cs_below_lower && boost_level != '0 |=> boost_level == $past(boost_level) - 1'b1;
	endproperty
	a_boost_down: assert property (p_boost_down) else $error("boost did not fall by one");

	property p_boost_hold;
		@(posedge sys_clk) disable iff (!rst_b) !cs_above_upper && !cs_below_lower |=> $stable(boost_level);
	endproperty
	a_boost_hold: assert property (p_boost_hold) else $error("boost moved between thresholds");

	property p_uv;
		@(posedge sys_clk) disable iff (!rst_b)
		in_switch && mains_low && !cs_latch_level |=> state == ST_UV_STOP && !switching_enable;
	endproperty
	a_uv: assert property (p_uv) else $error("undervoltage did not stop");

	property p_eb_start;
		@(posedge sys_clk) disable iff (!rst_b)
		blank_done && !mains_low && !cs_latch_level |=> feedback_discharge_switch && eb_count == 8'h00;
	endproperty
	a_eb_start: assert property (p_eb_start) else $error("extended blanking not started");

	property p_eb_count;
		@(posedge sys_clk) disable iff (!rst_b)
		state == ST_EB_CHARGE && feedback_above_upper && !mains_low && !cs_latch_level
		|=> eb_count == $past(eb_count) + 8'h01;
	endproperty
	a_eb_count: assert property (p_eb_count) else $error("fault count not advanced");

	property p_eb_osc;
		@(posedge sys_clk) disable iff (!rst_b)
		state inside {ST_EB_DISCHARGE, ST_EB_CHARGE, ST_FINAL_PULL, ST_RECOVERY}
		|-> !feedback_contrib_enable && !soft_start_contrib_enable && switching_enable;
	endproperty
	a_eb_osc: assert property (p_eb_osc) else $error("wrong oscillator contributions");

	property p_olp_off;
		@(posedge sys_clk) disable iff (!rst_b)
		state inside {ST_OLP_ENTRY, ST_OLP_CHARGE, ST_OLP_DISCHARGE, ST_SETTLE} |-> !switching_enable;
	endproperty
	a_olp_off: assert property (p_olp_off) else $error("gates active in overload");

	property p_settle;
		@(posedge sys_clk) disable iff (!rst_b)
		state == ST_SETTLE |-> !restart_charge_source && !input_sense_discharge_switch && hysteresis_source_enable;
	endproperty
	a_settle: assert property (p_settle) else $error("settle sources wrong");

	property p_ss_no_olp;
		@(posedge sys_clk) disable iff (!rst_b)
		soft_start_active && feedback_above_upper && !cs_latch_level && !mains_low
		|=> state inside {ST_SOFT_START, ST_NORMAL} && !feedback_discharge_switch;
	endproperty
	a_ss_no_olp: assert property (p_ss_no_olp) else $error("overload timer ran in soft start");
endmodule : fault_sequencer

// ==== rtl/protection_pkg.sv ====
// Shared constants, states and register layout for the resonant fault protection sequencer
package protection_pkg;
	// System clock rate
	localparam int unsigned CLK_FREQ_MHZ = 20;
	// Over-current boost ramp time, zero to maximum
	localparam int unsigned OCP_RAMP_TIME_US = 1500;
	localparam int unsigned OCP_RAMP_CYCLES = OCP_RAMP_TIME_US * CLK_FREQ_MHZ;
	// Fixed blanking before extended blanking starts
	localparam int unsigned OLP_BLANK_TIME_MS = 20;
	localparam int unsigned OLP_BLANK_CYCLES = OLP_BLANK_TIME_MS * 1000 * CLK_FREQ_MHZ;
	// Soft start duration and number of frequency steps
	localparam int unsigned SS_TIME_MS = 32;
	localparam int unsigned SS_STEPS = 32;
	localparam int unsigned SS_STEP_CYCLES = SS_TIME_MS * 1000 * CLK_FREQ_MHZ / SS_STEPS;
	localparam logic [4:0] SS_START = 5'(SS_STEPS - 1);
	// Recovery window after the final feedback pull-down
	localparam int unsigned RECOVERY_TIME_US = 1000;
	localparam int unsigned RECOVERY_CYCLES = RECOVERY_TIME_US * CLK_FREQ_MHZ;
	// Input-sense settle blanking before a restart
	localparam int unsigned SETTLE_TIME_US = 1000;
	localparam int unsigned SETTLE_CYCLES = SETTLE_TIME_US * CLK_FREQ_MHZ;
	// Fault cycle counts
	localparam logic [7:0] EXT_BLANK_COUNT_DEF = 8'h04;
	localparam logic [7:0] RESTART_COUNT_DEF = 8'h08;
	// Widths
	localparam int unsigned TIMER_W = 20;
	localparam int unsigned BOOST_W = 15;
	// Register byte offsets
	localparam logic [3:0] REG_CONTROL = 4'h0;
	localparam logic [3:0] REG_STATUS = 4'h4;
	localparam logic [3:0] REG_LEVELS = 4'h8;
	localparam logic [3:0] REG_COUNTS = 4'hC;
	// Control fields and reset value
	localparam int unsigned CTRL_UV_EN_BIT = 0;
	localparam int unsigned CTRL_BOOST_EN_BIT = 1;
	localparam logic [1:0] CTRL_RESET = 2'h3;
	// Status fields
	localparam int unsigned STAT_STATE_LSB = 0;
	localparam int unsigned STAT_SWITCH_BIT = 16;
	localparam int unsigned STAT_LATCH_BIT = 17;
	// Level and count fields
	localparam int unsigned LEV_BOOST_LSB = 0;
	localparam int unsigned LEV_SS_LSB = 16;
	localparam int unsigned CNT_EB_LSB = 0;
	localparam int unsigned CNT_RS_LSB = 8;
	// Sequencer states
	typedef enum logic [11:0] {
		ST_UV_STOP = 12'h001,
		ST_SOFT_START = 12'h002,
		ST_NORMAL = 12'h004,
		ST_EB_DISCHARGE = 12'h008,
		ST_EB_CHARGE = 12'h010,
		ST_FINAL_PULL = 12'h020,
		ST_RECOVERY = 12'h040,
		ST_OLP_ENTRY = 12'h080,
		ST_OLP_CHARGE = 12'h100,
		ST_OLP_DISCHARGE = 12'h200,
		ST_SETTLE = 12'h400,
		ST_LATCHED = 12'h800
	} state_t;
endpackage : protection_pkg

// ==== tb/resonant_fault_protection_sequencer_bench.sv ====
// Self-checking bench for the fault sequencer with its sensing network
`timescale 1ns/100ps
module resonant_fault_protection_sequencer_bench;
	import protection_pkg::*;
	localparam int unsigned RAMP = 16; // Short boost ramp
	localparam int unsigned BLANK = 20; // Short fixed blanking
	localparam int unsigned STEP = 8; // Short soft start step
	localparam logic [7:0] EXT = 8'h04; // Extended blanking cycles
	localparam logic [7:0] RST = 8'h02; // Restart delay cycles
	logic sys_clk = 0, rst_b = 0, cs_above_upper = 0, cs_below_lower = 0, cs_latch_level = 0;
	logic feedback_above_upper, feedback_below_lower, feedback_at_zero, input_sense_above_on;
	logic input_sense_high_level, input_sense_low_level, avs_read = 0, avs_write = 0, avs_waitrequest;
	logic [3:0] avs_address = 4'h0, avs_byteenable = 4'hF;
	logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
	logic [BOOST_W-1:0] boost_level;
	logic [4:0] soft_start_offset;
	logic soft_start_active, switching_enable, feedback_contrib_enable, soft_start_contrib_enable;
	logic feedback_discharge_switch, input_sense_discharge_switch, restart_charge_source;
	logic hysteresis_source_enable, latched_off, fault_on = 0, mains_ok = 1, dis_q = 0, chg_q = 0, ss_q = 0;
	int num_errors = 0, n_compared = 0, dis_rises = 0, chg_rises = 0, mix_bad = 0;
	int cyc = 0, ss_cyc = 0, t_ss = 0, t_dis = 0;
	// Free-running system clock
	always #25 sys_clk = ~sys_clk;
	fault_sequencer #(.EXT_BLANK_COUNT(EXT), .RESTART_COUNT(RST), .RAMP_CYCLES(RAMP), .BLANK_CYCLES(BLANK),
		.STEP_CYCLES(STEP), .RECOV_CYCLES(40), .SETTLE_CYC(10)) fault_sequencer_i (.sys_clk, .rst_b,
		.cs_above_upper, .cs_below_lower, .cs_latch_level, .feedback_above_upper, .feedback_below_lower,
		.feedback_at_zero, .input_sense_above_on, .input_sense_high_level, .input_sense_low_level,
		.avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
		.avs_waitrequest, .boost_level, .soft_start_offset, .soft_start_active, .switching_enable,
		.feedback_contrib_enable, .soft_start_contrib_enable, .feedback_discharge_switch,
		.input_sense_discharge_switch, .restart_charge_source, .hysteresis_source_enable, .latched_off);
	sense_network_model sense_network_model_i (.sys_clk, .fault_on, .mains_ok, .feedback_discharge_switch,
		.input_sense_discharge_switch, .restart_charge_source, .feedback_above_upper, .feedback_below_lower,
		.feedback_at_zero, .input_sense_above_on, .input_sense_high_level, .input_sense_low_level);
	// Pulse counters and timestamps of the switch activity
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		dis_q <= feedback_discharge_switch;
		chg_q <= restart_charge_source;
		ss_q <= soft_start_active;
		if (soft_start_active === 1'b1 && dis_rises == 0) ss_cyc <= ss_cyc + 1;
		if (ss_q === 1'b1 && soft_start_active === 1'b0 && dis_rises == 0) t_ss <= cyc;
		if (feedback_discharge_switch === 1'b1 && !dis_q) dis_rises <= dis_rises + 1;
		if (feedback_discharge_switch === 1'b1 && !dis_q && dis_rises == 0) t_dis <= cyc;
		if (restart_charge_source === 1'b1 && !chg_q) chg_rises <= chg_rises + 1;
		if (feedback_discharge_switch && (feedback_contrib_enable || soft_start_contrib_enable)) mix_bad <= 1;
	end
	// Compare and count
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// One bus transfer, held until waitrequest is sampled low at a rising edge
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd, output logic [31:0] d);
		int i;
		i = 0;
		@(posedge sys_clk);
		avs_address <= a;
		avs_writedata <= wd;
		avs_write <= wr;
		avs_read <= !wr;
		// Values read here are those standing just before the edge
		do begin
			@(posedge sys_clk);
			i++;
		end while (avs_waitrequest !== 1'b0 && i < 20);
		if (avs_waitrequest !== 1'b0) chk(32'(avs_waitrequest), 32'h0);
		d = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask : bus
	// Poll the status register until the state shows up
	task automatic wait_st(input state_t s);
		for (int i = 0; i < 300; i++) begin
			bus(1'b0, REG_STATUS, 32'h0, rd);
			if (rd[11:0] === s) break;
		end
		chk(32'(rd[11:0]), 32'(s));
	endtask : wait_st
	// Wait on a pulse counter with a bound
	task automatic wait_cnt(ref int c, input int n);
		for (int i = 0; i < 5000 && c < n; i++) @(posedge sys_clk);
		#1;
		if (c < n) chk(32'(c), 32'(n));
	endtask : wait_cnt
	// Hold current-sense decisions for n edges, changed only at a rising edge
	task cs_run(input logic up, input logic dn, input int n);
		@(posedge sys_clk);
		cs_above_upper <= up;
		cs_below_lower <= dn;
		repeat (n) @(posedge sys_clk);
		cs_above_upper <= 1'b0;
		cs_below_lower <= 1'b0;
		#1;
	endtask : cs_run
	// Verdict and end of run
	task end_of_test;
		if (num_errors == 0 && n_compared > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : end_of_test
	// Main sequence
	initial begin
		repeat (12) @(posedge sys_clk);
		rst_b <= 1'b1;
		fault_on <= 1'b1;
		bus(1'b0, REG_CONTROL, 32'h0, rd);
		chk(32'(rd[1:0]), 32'(CTRL_RESET));
		bus(1'b0, REG_STATUS, 32'h0, rd);
		chk(32'(rd[11:0]), 32'(ST_SOFT_START));
		chk(32'(soft_start_offset), 32'(SS_START));
		wait_cnt(dis_rises, 1);
		chk(32'(ss_cyc / STEP), 32'h20);
		chk(32'(t_dis - t_ss >= BLANK && t_dis - t_ss <= BLANK + 2), 32'h1);
		wait_cnt(chg_rises, 1);
		chk(32'({switching_enable, latched_off}), 32'h0);
		chk(32'(dis_rises), 32'(EXT) + 32'h1);
		chk(32'(mix_bad), 32'h0);
		fault_on <= 1'b0;
		mains_ok <= 1'b0;
		wait_st(ST_SETTLE);
		chk(32'({hysteresis_source_enable, restart_charge_source, input_sense_discharge_switch}), 32'h4);
		chk(32'(chg_rises), 32'(RST));
		wait_st(ST_UV_STOP);
		mains_ok <= 1'b1;
		wait_st(ST_SOFT_START);
		wait_st(ST_NORMAL);
		chk(32'(soft_start_offset), 32'h0);
		chk(32'({feedback_contrib_enable, soft_start_contrib_enable}), 32'h2);
		cs_run(1'b1, 1'b0, 5);
		chk(32'(boost_level), 32'h5);
		cs_run(1'b0, 1'b0, 6);
		chk(32'(boost_level), 32'h5);
		cs_run(1'b1, 1'b0, RAMP);
		chk(32'(boost_level), RAMP);
		cs_run(1'b0, 1'b1, 3);
		chk(32'(boost_level), RAMP - 3);
		cs_run(1'b0, 1'b1, RAMP);
		chk(32'(boost_level), 32'h0);
		bus(1'b1, REG_CONTROL, 32'h1, rd);
		cs_run(1'b1, 1'b0, 4);
		chk(32'(boost_level), 32'h0);
		bus(1'b1, REG_CONTROL, 32'(CTRL_RESET), rd);
		repeat (2) begin
			fault_on <= 1'b1;
			repeat (15) @(posedge sys_clk);
			fault_on <= 1'b0;
			repeat (3) @(posedge sys_clk);
		end
		bus(1'b0, REG_STATUS, 32'h0, rd);
		chk(32'(rd[11:0]), 32'(ST_NORMAL));
		mains_ok <= 1'b0;
		wait_st(ST_UV_STOP);
		chk(32'(switching_enable), 32'h0);
		mains_ok <= 1'b1;
		wait_st(ST_NORMAL);
		fault_on <= 1'b1;
		wait_cnt(dis_rises, 2 * EXT + 2);
		fault_on <= 1'b0;
		wait_st(ST_NORMAL);
		bus(1'b0, REG_COUNTS, 32'h0, rd);
		chk(32'(rd[7:0]), 32'h0);
		chk(32'(chg_rises), 32'(RST));
		bus(1'b0, 4'h2, 32'h0, rd);
		chk(rd, 32'h0);
		cs_latch_level <= 1'b1;
		@(posedge sys_clk);
		cs_latch_level <= 1'b0;
		#1;
		chk(32'({latched_off, switching_enable}), 32'h2);
		repeat (30) @(posedge sys_clk);
		chk(32'(latched_off), 32'h1);
		rst_b <= 1'b0;
		@(posedge sys_clk);
		rst_b <= 1'b1;
		#1;
		chk(32'(latched_off), 32'h0);
		end_of_test;
	end
	// Watchdog against a hang
	initial begin
		repeat (40000) @(posedge sys_clk);
		num_errors++;
		end_of_test;
	end
endmodule : resonant_fault_protection_sequencer_bench

// ==== tb/sense_network_model.sv ====
// Behavioural feedback pin, input-sense pin and power stage around the sequencer
`timescale 1ns/100ps
module sense_network_model (
	input wire logic sys_clk,
	input wire logic fault_on,
	input wire logic mains_ok,
	input wire logic feedback_discharge_switch,
	input wire logic input_sense_discharge_switch,
	input wire logic restart_charge_source,
	output logic feedback_above_upper,
	output logic feedback_below_lower,
	output logic feedback_at_zero,
	output logic input_sense_above_on,
	output logic input_sense_high_level,
	output logic input_sense_low_level
);
	int fb = 5; // Feedback pin level, 10 is the upper threshold
	int vin = 8; // Input-sense pin level, 10 is the high level
	// Each pin moves one step a cycle toward whatever pulls it
	always @(posedge sys_clk) begin
		if (feedback_discharge_switch) begin
			fb <= (fb > 0) ? fb - 1 : 0;
		end else if (fault_on) begin
			fb <= (fb < 10) ? fb + 1 : 10; // Open loop recharges the pin
		end else begin
			fb <= (fb > 5) ? fb - 1 : ((fb < 5) ? fb + 1 : 5); // Loop regulates
		end
		if (input_sense_discharge_switch) begin
			vin <= (vin > 0) ? vin - 1 : 0;
		end else if (restart_charge_source) begin
			vin <= (vin < 10) ? vin + 1 : 10;
		end else if (mains_ok) begin
			vin <= (vin > 8) ? vin - 1 : ((vin < 8) ? vin + 1 : 8); // Divider settles
		end else begin
			vin <= (vin > 0) ? vin - 1 : 0; // Mains gone
		end
	end
	// Comparator decisions seen by the sequencer
	assign feedback_above_upper = (fb >= 10);
	assign feedback_below_lower = (fb <= 2);
	assign feedback_at_zero = (fb == 0);
	assign input_sense_above_on = (vin >= 6);
	assign input_sense_high_level = (vin >= 10);
	assign input_sense_low_level = (vin <= 1);
endmodule : sense_network_model
